// ==== hdl/bprd_pkg.sv ====
// Purpose: shared constants and carriers for the bank/port/return decoder
// Assumes: 10-bit instruction words, 4-bit data path
// Notes:   opcodes of the handled instructions are fixed here
package bprd_pkg;
    localparam int        IW         = 10;
    localparam int        PCW        = 11;
    localparam int        SPW        = 3;
    localparam int        PAGEW      = 7;
    localparam int        PORTW      = 8;
    localparam logic [9:0] OP_BANKCLR = 10'h040;
    localparam logic [9:0] OP_CYCLR   = 10'h006;
    localparam logic [9:0] OP_PORTCLR = 10'h014;
    localparam logic [9:0] OP_SUBRET  = 10'h044;
    localparam logic [9:0] OP_INTRET  = 10'h046;
    localparam logic [6:0] PAGE_LOW_MASK = 7'h3F;
    localparam logic [7:0] PORT_RESET    = 8'hFF;
    localparam logic [2:0] SP_RESET      = 3'h7;

    typedef struct packed {
        logic [3:0] ptrX;
        logic [3:0] ptrY;
        logic [3:0] ptrZ;
        logic       carry;
        logic       skipPending;
        logic       nopMode;
        logic [3:0] accA;
        logic [3:0] regB;
    } bprd_ctx_t;

    typedef enum logic [1:0] {
        BPRD_IDLE,
        BPRD_SUBRET2
    } bprd_state_t;
endpackage

// ==== hdl/bprd_decoder.sv ====
// Purpose: executes bank clear, carry clear, port bit clear and returns
// Assumes: one instruction word offered per cycle with instrValid
// Notes:   outputs are registered; ctx is the live context, savedCtx the one from entry
`timescale 1ns/100ps
module bprd_decoder #(
    parameter int DEPTH = 8
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       instrValid,
    input  wire logic [bprd_pkg::IW-1:0]    instrWord,
    input  wire logic [bprd_pkg::PAGEW-1:0] tablePageIn,
    input  wire logic                       tableFetch,
    input  wire logic [3:0]                 indexY,
    input  wire logic                       pushValid,
    input  wire logic [bprd_pkg::PCW-1:0]   pushPc,
    input  wire bprd_pkg::bprd_ctx_t        ctxIn,
    input  wire bprd_pkg::bprd_ctx_t        savedCtx,
    output logic [bprd_pkg::PCW-1:0]        pcOut,
    output logic                            pcLoad,
    output logic [bprd_pkg::SPW-1:0]        stackPointer,
    output logic                            bankFlag,
    output logic [bprd_pkg::PAGEW-1:0]      tablePageOut,
    output logic [bprd_pkg::PORTW-1:0]      portD,
    output bprd_pkg::bprd_ctx_t             ctxOut,
    output logic                            ctxLoad,
    output logic                            busy
);
    import bprd_pkg::*;

    // the pointer wraps by its width, so the stack must match it exactly
    if (DEPTH != (1 << SPW)) begin : g_depth_check
        $error("DEPTH must equal 2**SPW");
    end

    logic [PCW-1:0] returnStack [DEPTH];
    bprd_state_t    state;
    logic           take;
    logic           intretTake;

    assign take = instrValid && state == BPRD_IDLE;
    // a push on the same edge wins; the return is then not taken at all
    assign intretTake = take && !pushValid && instrWord == OP_INTRET;

    // no reset on the stack words: each is written before a return reads it
    always_ff @(posedge clock) begin
        if (pushValid) begin
            returnStack[SPW'(stackPointer + 3'h1)] <= pushPc;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state        <= BPRD_IDLE;
            stackPointer <= SP_RESET;
            pcOut        <= '0;
            pcLoad       <= 1'b0;
            busy         <= 1'b0;
        end else begin
            pcLoad <= 1'b0;
            busy   <= 1'b0;
            unique case (state)
                BPRD_IDLE: begin
                    if (pushValid) begin
                        stackPointer <= stackPointer + 3'h1;
                    end else if (take && instrWord == OP_SUBRET) begin
                        state <= BPRD_SUBRET2;
                        busy  <= 1'b1;
                    end else if (take && instrWord == OP_INTRET) begin
                        pcOut        <= returnStack[stackPointer];
                        pcLoad       <= 1'b1;
                        stackPointer <= stackPointer - 3'h1;
                    end
                end
                BPRD_SUBRET2: begin
                    pcOut        <= returnStack[stackPointer];
                    pcLoad       <= 1'b1;
                    stackPointer <= stackPointer - 3'h1;
                    state        <= BPRD_IDLE;
                end
                // two-bit state holds codes no branch reaches; fall back to idle
                default: begin
                    state <= BPRD_IDLE;
                end
            endcase
        end
    end

    // bank flag set elsewhere in the core; reset leaves the full range open
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bankFlag <= 1'b1;
        end else if (take && instrWord == OP_BANKCLR) begin
            bankFlag <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tablePageOut <= '0;
        end else if (tableFetch) begin
            tablePageOut <= bankFlag ? tablePageIn
                                     : (tablePageIn & PAGE_LOW_MASK);
        end
    end

    // index above 7 is left undefined to software; hardware ignores it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            portD <= PORT_RESET;
        end else if (take && instrWord == OP_PORTCLR && indexY < 4'h8) begin
            portD[indexY[2:0]] <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctxOut  <= '0;
            ctxLoad <= 1'b0;
        end else begin
            ctxLoad <= 1'b0;
            if (intretTake) begin
                ctxOut  <= savedCtx;
                ctxLoad <= 1'b1;
            end else if (take && instrWord == OP_CYCLR) begin
                ctxOut       <= ctxIn;
                ctxOut.carry <= 1'b0;
                ctxLoad      <= 1'b1;
            end
        end
    end

    sequence s_subret_taken;
        take && instrWord == OP_SUBRET && !pushValid;
    endsequence

    sequence s_intret_taken;
        take && instrWord == OP_INTRET && !pushValid;
    endsequence

    chk_subret_two_cycles: assert property (@(posedge clock) disable iff (!rst_n)
        s_subret_taken |=> busy && !pcLoad ##1 pcLoad)
        else $error("subroutine return not two cycles");
    chk_subret_sp_dec: assert property (@(posedge clock) disable iff (!rst_n)
        s_subret_taken |=> ##1 stackPointer == $past(stackPointer, 2) - 3'h1)
        else $error("subroutine return pointer wrong");
    chk_intret_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
        take && instrWord == OP_INTRET && !pushValid |=> pcLoad && ctxLoad
            && stackPointer == $past(stackPointer) - 3'h1)
        else $error("interrupt return not one cycle");
    chk_intret_ctx: assert property (@(posedge clock) disable iff (!rst_n)
        s_intret_taken |=> ctxOut == $past(savedCtx))
        else $error("context not restored");
    chk_intret_acc: assert property (@(posedge clock) disable iff (!rst_n)
        s_intret_taken |=> ctxOut.accA == $past(savedCtx.accA)
            && ctxOut.regB == $past(savedCtx.regB))
        else $error("accumulator not restored");
    chk_bank_clear: assert property (@(posedge clock) disable iff (!rst_n)
        take && instrWord == OP_BANKCLR |=> !bankFlag)
        else $error("bank flag not cleared");
    chk_page_range: assert property (@(posedge clock) disable iff (!rst_n)
        tableFetch && !bankFlag |=> tablePageOut <= 7'd63)
        else $error("page above 63 with bank cleared");
    chk_port_clear: assert property (@(posedge clock) disable iff (!rst_n)
        take && instrWord == OP_PORTCLR && indexY < 4'h8 |=> portD[$past(indexY[2:0])] == 1'b0)
        else $error("port bit not cleared");
    chk_carry_clear: assert property (@(posedge clock) disable iff (!rst_n)
        take && instrWord == OP_CYCLR |=> !ctxOut.carry && ctxLoad
            && ctxOut.accA == $past(ctxIn.accA) && ctxOut.skipPending == $past(ctxIn.skipPending))
        else $error("carry clear wrong");

    // return path: stack word, pointer and the push that beats a return
    chk_subret_pc: assert property (@(posedge clock) disable iff (!rst_n)
        s_subret_taken |=> ##1 pcOut == $past(returnStack[stackPointer]))
        else $error("subroutine return address wrong");
    chk_intret_pc: assert property (@(posedge clock) disable iff (!rst_n)
        s_intret_taken |=> pcOut == $past(returnStack[stackPointer]))
        else $error("interrupt return address wrong");
    chk_busy_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
        busy |=> !busy)
        else $error("busy held too long");
    chk_busy_refuses: assert property (@(posedge clock) disable iff (!rst_n)
        busy |=> !ctxLoad && $stable(bankFlag) && $stable(portD))
        else $error("instruction taken while busy");
    chk_push_wins: assert property (@(posedge clock) disable iff (!rst_n)
        take && pushValid && (instrWord == OP_INTRET || instrWord == OP_SUBRET)
            |=> !pcLoad && !ctxLoad && !busy)
        else $error("return taken against a push");
    chk_push_sp_inc: assert property (@(posedge clock) disable iff (!rst_n)
        pushValid && state == BPRD_IDLE |=> stackPointer == $past(stackPointer) + 3'h1)
        else $error("push did not move the pointer");

    // port and carry: only the chosen bit and only the carry may move
    chk_port_hold: assert property (@(posedge clock) disable iff (!rst_n)
        take && instrWord == OP_PORTCLR && indexY >= 4'h8 |=> portD == $past(portD))
        else $error("port changed for index above seven");
    chk_port_others: assert property (@(posedge clock) disable iff (!rst_n)
        take && instrWord == OP_PORTCLR
            |=> ((portD ^ $past(portD)) & ~(8'h01 << $past(indexY[2:0]))) == 8'h00)
        else $error("port clear touched another bit");
    chk_carry_rest: assert property (@(posedge clock) disable iff (!rst_n)
        take && instrWord == OP_CYCLR |=> ctxOut.ptrX == $past(ctxIn.ptrX)
            && ctxOut.ptrZ == $past(ctxIn.ptrZ) && ctxOut.nopMode == $past(ctxIn.nopMode)
            && ctxOut.regB == $past(ctxIn.regB))
        else $error("carry clear changed other context");

    // table pages: full range while the bank flag stands, bit six low after
    chk_table_full: assert property (@(posedge clock) disable iff (!rst_n)
        tableFetch && bankFlag |=> tablePageOut == $past(tablePageIn))
        else $error("table page altered with bank flag set");
    chk_table_bit6: assert property (@(posedge clock) disable iff (!rst_n)
        tableFetch && !bankFlag |=> !tablePageOut[PAGEW-1]
            && tablePageOut[PAGEW-2:0] == $past(tablePageIn[PAGEW-2:0]))
        else $error("table page bit six not forced low");
endmodule // bprd_decoder

// ==== verification/bprd_decoder_tb_top.sv ====
// Purpose: random and corner checks of the bank, port and return decoder
// Assumes: outputs settle 1 ns after the rising edge
// Notes:   expected values come from bench-side models only
`timescale 1ns/100ps
module bprd_decoder_tb_top;
    import bprd_pkg::*;
    logic             clock = 0, rst_n = 0, instrValid = 0, tableFetch = 0, pushValid = 0;
    logic [IW-1:0]    instrWord = '0;
    logic [PAGEW-1:0] tablePageIn = '0, tablePageOut;
    logic [3:0]       indexY = '0;
    logic [PCW-1:0]   pushPc = '0, pcOut;
    bprd_ctx_t        ctxIn = '0, savedCtx = '0, ctxOut, c;
    logic [SPW-1:0]   stackPointer, expSp;
    logic [PORTW-1:0] portD, expPort;
    logic             pcLoad, bankFlag, ctxLoad, busy;
    int               num_errors = 0, samples_checked = 0;
    bprd_decoder dut_u (.clock(clock), .rst_n(rst_n), .instrValid(instrValid),
        .instrWord(instrWord), .tablePageIn(tablePageIn), .tableFetch(tableFetch),
        .indexY(indexY), .pushValid(pushValid), .pushPc(pushPc), .ctxIn(ctxIn),
        .savedCtx(savedCtx), .pcOut(pcOut), .pcLoad(pcLoad), .stackPointer(stackPointer),
        .bankFlag(bankFlag), .tablePageOut(tablePageOut), .portD(portD),
        .ctxOut(ctxOut), .ctxLoad(ctxLoad), .busy(busy));
    always #2.5 clock = ~clock;
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    task automatic close_out();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // whole run is far shorter; a hang lands here
    initial begin
        #100000;
        num_errors++;
        close_out();
    end
    // bank flag clear forces page bit six low, the rest passes through
    function automatic logic [PAGEW-1:0] exp_page(logic [PAGEW-1:0] page, logic full);
        return full ? page : {1'b0, page[PAGEW-2:0]};
    endfunction
    function automatic bprd_ctx_t rand_ctx();
        logic [31:0] r;
        r = $urandom;
        return r[$bits(bprd_ctx_t)-1:0];
    endfunction
    initial begin
        logic [3:0] y;
        logic [PCW-1:0] pc;
        logic [PCW-1:0] stk [3];
        y = 4'($urandom(32'hFC64CA0E));
        repeat (20) @(posedge clock);
        #1 rst_n = 1;
        expSp = SP_RESET;
        expPort = PORT_RESET;
        check("bankFlag", bankFlag, 1);
        check("portD", portD, expPort);
        check("stackPointer", stackPointer, expSp);
        for (int b = 1; b >= 0; b--) begin
            tableFetch = 1;
            for (int i = 0; i < 5; i++) begin
                tablePageIn = (i == 0) ? 7'h7F : PAGEW'($urandom);
                step();
                check("tablePage", tablePageOut, exp_page(tablePageIn, b[0]));
            end
            tableFetch = 0;
            instrValid = 1;
            instrWord = OP_BANKCLR;
            step();
            instrValid = 0;
            check("bankFlag", bankFlag, 0);
        end
        step();
        instrValid = 1;
        instrWord = OP_PORTCLR;
        for (int i = 0; i < 14; i++) begin
            y = (i == 3) ? 4'hF : (i == 4) ? 4'h8 : 4'($urandom);
            indexY = y;
            step();
            if (y < 8) expPort[y[2:0]] = 1'b0;
            check("portD", portD, expPort);
        end
        instrWord = OP_CYCLR;
        repeat (3) begin
            ctxIn = rand_ctx();
            c = ctxIn;
            c.carry = 1'b0;
            step();
            check("ctxLoad", ctxLoad, 1);
            check("ctxOut", ctxOut, c);
        end
        instrValid = 0;
        for (int r = 0; r < 6; r++) begin
            pc = PCW'($urandom);
            pushPc = pc;
            pushValid = 1;
            step();
            pushValid = 0;
            savedCtx = rand_ctx();
            instrValid = 1;
            instrWord = r[0] ? OP_INTRET : OP_SUBRET;
            step();
            if (!r[0]) begin
                instrWord = OP_CYCLR; // offered in the busy cycle, must be refused
                check("busy", busy, 1);
                check("pcLoad early", pcLoad, 0);
                step();
            end
            instrValid = 0;
            expSp = expSp + 1'b1 - 1'b1;
            check("pcLoad", pcLoad, 1);
            check("pcOut", pcOut, pc);
            check("stackPointer", stackPointer, expSp);
            if (r[0]) check("ctxOut", ctxOut, savedCtx);
            check("ctxLoad", ctxLoad, r[0]);
        end
        // three nested pushes, the last against a return, then back-to-back unwinding
        for (int r = 0; r < 3; r++) begin
            stk[r] = PCW'($urandom);
            pushPc = stk[r];
            pushValid = 1;
            if (r == 2) begin
                instrValid = 1;
                instrWord = OP_INTRET;
            end
            step();
            check("stackPointer", stackPointer, SPW'(expSp + r + 1));
        end
        pushValid = 0;
        check("pcLoad push wins", pcLoad, 0);
        check("ctxLoad push wins", ctxLoad, 0);
        for (int r = 2; r >= 0; r--) begin
            savedCtx = rand_ctx();
            step();
            check("pcLoad", pcLoad, 1);
            check("pcOut", pcOut, stk[r]);
            check("stackPointer", stackPointer, SPW'(expSp + r));
            check("ctxOut", ctxOut, savedCtx);
        end
        instrValid = 0;
        // mid-run reset must reopen the full page range and restore the port
        rst_n = 0;
        step();
        rst_n = 1;
        check("bankFlag", bankFlag, 1);
        check("portD", portD, PORT_RESET);
        check("stackPointer", stackPointer, SP_RESET);
        tableFetch = 1;
        tablePageIn = 7'h7F;
        step();
        tableFetch = 0;
        check("tablePage", tablePageOut, exp_page(7'h7F, 1'b1));
        close_out();
    end
endmodule // bprd_decoder_tb_top
